// *** rtl/lbf_pkg.sv ***
// lbf_pkg: constants, types and register layout for the low bus fault response select block
// assumes a single 100 MHz clock domain and byte-wide register access
package lbf_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] LBF_ADDR_CTRL1 = 8'hB0;
  localparam logic [7:0] LBF_ADDR_RESP = 8'hB1;
  localparam logic [7:0] LBF_ADDR_STATUS = 8'hD2;
  localparam logic [7:0] LBF_RESET_VAL = 8'h00;
  localparam int LBF_IND_EN_BIT = 7;
  localparam int LBF_CLR_BIT = 6;
  localparam int LBF_NUM_EV = 3;
  localparam int LBF_FIELD_W = 2;
  // event index: also field index and status bit
  localparam int LBF_EV_OUT_OV = 0;
  localparam int LBF_EV_OUT_UV = 1;
  localparam int LBF_EV_IN_OV = 2;
  // ==========================================================
  // timing
  localparam int LBF_CLK_MHZ = 100;
  localparam int LBF_HICCUP_MS = 500;
  localparam int LBF_HICCUP_CYC = LBF_HICCUP_MS * 1000 * LBF_CLK_MHZ;
  localparam int LBF_CNT_W = 26;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    LBF_RESP_FLAG = 2'h0,
    LBF_RESP_HICCUP = 2'h1,
    LBF_RESP_LATCH = 2'h2,
    LBF_RESP_FLAG2 = 2'h3
  } lbf_resp_t;
  typedef enum logic [1:0] {
    LBF_ST_RUN = 2'h0,
    LBF_ST_HALT = 2'h1,
    LBF_ST_WAIT = 2'h2,
    LBF_ST_LATCHED = 2'h3
  } lbf_state_t;
  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lbf_wr_t;
endpackage

// *** rtl/lbf_event_ch.sv ***
// lbf_event_ch: per-event halt state machine with hiccup restart counter
// assumes fault_i already synchronised and on sys_clk
`timescale 1ns/1ps
module lbf_event_ch
  import lbf_pkg::*;
#(
  parameter logic [LBF_CNT_W-1:0] HICCUP_CYC = LBF_CNT_W'(LBF_HICCUP_CYC)
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic fault_i,
  input wire lbf_pkg::lbf_resp_t resp_i,
  input wire logic restart_i,
  output logic halt_o
);
  lbf_state_t st_r, st_nxt;
  logic [LBF_CNT_W-1:0] cnt_r, cnt_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      LBF_ST_RUN: begin
        cnt_nxt = '0;
        if (fault_i && resp_i == LBF_RESP_HICCUP) begin
          st_nxt = LBF_ST_HALT;
        end else if (fault_i && resp_i == LBF_RESP_LATCH) begin
          st_nxt = LBF_ST_LATCHED;
        end
      end
      LBF_ST_HALT: begin
        cnt_nxt = '0;
        if (!fault_i) begin
          st_nxt = LBF_ST_WAIT;
        end
      end
      LBF_ST_WAIT: begin
        if (fault_i) begin
          st_nxt = LBF_ST_HALT;
          cnt_nxt = '0;
        end else if (cnt_r >= HICCUP_CYC - LBF_CNT_W'(1)) begin
          st_nxt = LBF_ST_RUN;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + LBF_CNT_W'(1);
        end
      end
      LBF_ST_LATCHED: begin
        // only an enable toggle frees it, even if fault stays gone
        if (restart_i) begin
          st_nxt = LBF_ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= LBF_ST_RUN;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign halt_o = (st_r != LBF_ST_RUN);

  chk_wait_bounded: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_r == LBF_ST_WAIT) |-> (cnt_r < HICCUP_CYC))
    else $error("hiccup counter overran");
  chk_refault_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_r == LBF_ST_WAIT && fault_i) |=> (st_r == LBF_ST_HALT && cnt_r == '0))
    else $error("refault did not restart delay");
  chk_latch_holds: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_r == LBF_ST_LATCHED && !restart_i) |=> (st_r == LBF_ST_LATCHED))
    else $error("latch-off released without toggle");
endmodule

// *** rtl/lbf_top.sv ***
// lbf_top: low voltage bus fault response selection with control, response and status registers
// assumes fault inputs and enables come from other domains; register writes are on sys_clk
`timescale 1ns/1ps
module lbf_top
  import lbf_pkg::*;
#(
  parameter logic [LBF_CNT_W-1:0] HICCUP_CYC = LBF_CNT_W'(LBF_HICCUP_CYC)
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire lbf_pkg::lbf_wr_t reg_wr,
  input wire logic [7:0] reg_raddr,
  input wire logic [LBF_NUM_EV-1:0] fault_in,
  input wire lbf_pkg::lbf_resp_t strap_resp,
  input wire logic sw_enable,
  input wire logic chip_enable,
  output logic [7:0] reg_rdata,
  output logic fault_flag_n,
  output logic switching_on
);
  import lbf_pkg::*;

  // ==========================================================
  // input synchronisers
  logic [LBF_NUM_EV+1:0] sync1_r, sync2_r;
  logic [1:0] strap1_r, strap2_r;
  // enables idle high; starting the chain there avoids a false toggle after reset
  localparam logic [LBF_NUM_EV+1:0] SYNC_IDLE = {2'h3, {LBF_NUM_EV{1'b0}}};
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
      strap1_r <= '0;
      strap2_r <= '0;
    end else begin
      sync1_r <= {chip_enable, sw_enable, fault_in};
      sync2_r <= sync1_r;
      strap1_r <= strap_resp;
      strap2_r <= strap1_r;
    end
  end
  logic [LBF_NUM_EV-1:0] fault_s;
  assign fault_s = sync2_r[LBF_NUM_EV-1:0];

  // ==========================================================
  // registers
  logic [7:0] ctrl1_r, ctrl1_nxt, resp_r, resp_nxt;
  logic [LBF_NUM_EV-1:0] stat_r, stat_nxt;
  logic [1:0] en_d_r;
  logic restart;
  logic [7:0] rdata_nxt;
  logic clr;
  assign clr = ctrl1_r[LBF_CLR_BIT];
  // a toggle is any edge on either enable
  assign restart = (en_d_r != sync2_r[LBF_NUM_EV+1:LBF_NUM_EV]);

  always_comb begin
    ctrl1_nxt = ctrl1_r;
    resp_nxt = resp_r;
    if (reg_wr.wr_en && reg_wr.addr == LBF_ADDR_CTRL1) begin
      ctrl1_nxt = reg_wr.wdata;
    end
    if (reg_wr.wr_en && reg_wr.addr == LBF_ADDR_RESP) begin
      resp_nxt = reg_wr.wdata;
    end
    // held clear while bit is one; faults re-set the cycle it returns to zero
    if (clr) begin
      stat_nxt = '0;
    end else begin
      stat_nxt = stat_r | fault_s;
    end
    unique case (reg_raddr)
      LBF_ADDR_CTRL1: rdata_nxt = ctrl1_r;
      LBF_ADDR_RESP: rdata_nxt = resp_r;
      LBF_ADDR_STATUS: rdata_nxt = {{(8 - LBF_NUM_EV){1'b0}}, stat_r};
      default: rdata_nxt = LBF_RESET_VAL;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl1_r <= LBF_RESET_VAL;
      resp_r <= LBF_RESET_VAL;
      stat_r <= '0;
      en_d_r <= 2'h3;
      reg_rdata <= LBF_RESET_VAL;
    end else begin
      ctrl1_r <= ctrl1_nxt;
      resp_r <= resp_nxt;
      stat_r <= stat_nxt;
      en_d_r <= sync2_r[LBF_NUM_EV+1:LBF_NUM_EV];
      reg_rdata <= rdata_nxt;
    end
  end

  // ==========================================================
  // per-event response selection and halt tracking
  logic [LBF_NUM_EV-1:0] halt;
  lbf_resp_t sel_resp [LBF_NUM_EV];
  genvar gi;
  generate
    for (gi = 0; gi < LBF_NUM_EV; gi++) begin : g_ev
      // fields at 1:0, 3:2, 5:4; code 11 falls through as flag only
      assign sel_resp[gi] = ctrl1_r[LBF_IND_EN_BIT] ?
        lbf_resp_t'(resp_r[gi*LBF_FIELD_W +: LBF_FIELD_W]) :
        lbf_resp_t'(strap2_r);
      lbf_event_ch #(
        .HICCUP_CYC(HICCUP_CYC)
      ) u_ch (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .fault_i(fault_s[gi]),
        .resp_i(sel_resp[gi]),
        .restart_i(restart),
        .halt_o(halt[gi])
      );
    end
  endgenerate

  // ==========================================================
  // outputs
  logic flag_n_nxt, sw_on_nxt;
  always_comb begin
    flag_n_nxt = ~(|stat_nxt);
    // codes 00 and 11 never halt, so switching stays on for them
    sw_on_nxt = ~(|halt);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fault_flag_n <= 1'b1;
      switching_on <= 1'b1;
    end else begin
      fault_flag_n <= flag_n_nxt;
      switching_on <= sw_on_nxt;
    end
  end

  // ==========================================================
  // checks
  chk_status_sets: assert property (@(posedge sys_clk) disable iff (!rstn)
    (fault_s[LBF_EV_OUT_OV] && !clr) |=> stat_r[LBF_EV_OUT_OV])
    else $error("out ov status not set");
  chk_uv_status: assert property (@(posedge sys_clk) disable iff (!rstn)
    (fault_s[LBF_EV_OUT_UV] && !clr) |=> stat_r[LBF_EV_OUT_UV])
    else $error("out uv status not set");
  chk_inov_status: assert property (@(posedge sys_clk) disable iff (!rstn)
    (fault_s[LBF_EV_IN_OV] && !clr) |=> stat_r[LBF_EV_IN_OV])
    else $error("in ov status not set");
  chk_flag_follows: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(|stat_r) |-> !fault_flag_n)
    else $error("fault flag not low with status");
  chk_clear_works: assert property (@(posedge sys_clk) disable iff (!rstn)
    clr |=> (stat_r == '0))
    else $error("status not cleared");
  chk_flag_only: assert property (@(posedge sys_clk) disable iff (!rstn)
    (sel_resp[LBF_EV_OUT_OV] inside {LBF_RESP_FLAG, LBF_RESP_FLAG2} && !halt[LBF_EV_OUT_OV])
      |=> !halt[LBF_EV_OUT_OV])
    else $error("flag-only response halted");
  chk_hiccup_halts: assert property (@(posedge sys_clk) disable iff (!rstn)
    (fault_s[LBF_EV_OUT_UV] && sel_resp[LBF_EV_OUT_UV] == LBF_RESP_HICCUP) |=> ##1 !switching_on)
    else $error("hiccup did not stop switching");
  chk_strap_used: assert property (@(posedge sys_clk) disable iff (!rstn)
    !ctrl1_r[LBF_IND_EN_BIT] |-> (sel_resp[LBF_EV_IN_OV] == lbf_resp_t'(strap2_r)))
    else $error("strap default not applied");
endmodule

// *** testbench/lbf_mcu_model.sv ***
// lbf_mcu_model: system controller that writes, reads and clears the fault registers
// assumes the bench calls its tasks; read data shows one cycle after the address
`timescale 1ns/1ps
module lbf_mcu_model
  import lbf_pkg::*;
(
  input wire logic sys_clk,
  output lbf_pkg::lbf_wr_t reg_wr,
  output logic [7:0] reg_raddr,
  input wire logic [7:0] reg_rdata
);
  import lbf_pkg::*;
  // ==========================================================
  // register access
  initial begin
    reg_wr = '0;
    reg_raddr = 8'h00;
  end
  // released lines show the inverse so stale values never pass
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = '{wr_en: 1'b1, addr: a, wdata: d};
    @(negedge sys_clk);
    reg_wr = '{wr_en: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_raddr = a;
    repeat (2) @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task clear_faults(input logic [7:0] base);
    wr(LBF_ADDR_CTRL1, base | 8'h40);
    wr(LBF_ADDR_CTRL1, base & 8'hBF);
  endtask
endmodule

// *** testbench/tb.sv ***
// tb: self-checking bench for lbf_top, short hiccup count
// assumes lbf_pkg compiled first and the controller model beside it
`timescale 1ns/1ps
module tb;
  import lbf_pkg::*;
  localparam logic [LBF_CNT_W-1:0] HC = LBF_CNT_W'(20);
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  lbf_wr_t reg_wr;
  logic [7:0] reg_raddr, reg_rdata, rdv, ctrl;
  logic [2:0] fault_in = 3'h0;
  lbf_resp_t strap_resp = LBF_RESP_FLAG;
  logic sw_enable = 1'b1;
  logic chip_enable = 1'b1;
  logic fault_flag_n, switching_on;
  logic [15:0] lfsr = 16'h37BF;
  int bad_count = 0;
  int tests_run = 0;
  always #5 sys_clk = ~sys_clk;
  lbf_top #(.HICCUP_CYC(HC)) u_lbf_top (.sys_clk(sys_clk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_raddr(reg_raddr), .fault_in(fault_in), .strap_resp(strap_resp),
    .sw_enable(sw_enable), .chip_enable(chip_enable), .reg_rdata(reg_rdata),
    .fault_flag_n(fault_flag_n), .switching_on(switching_on));
  lbf_mcu_model u_lbf_mcu_model (.sys_clk(sys_clk), .reg_wr(reg_wr),
    .reg_raddr(reg_raddr), .reg_rdata(reg_rdata));
  // ==========================================================
  // helpers
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic halts(input lbf_resp_t c);
    return (c == LBF_RESP_HICCUP) || (c == LBF_RESP_LATCH);
  endfunction
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task test_done();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // one event with the response c in force
  task ev(input int i, input lbf_resp_t c);
    fault_in[i] = 1'b1;
    cyc(6);
    u_lbf_mcu_model.rd(LBF_ADDR_STATUS, rdv);
    chk("status", 8'h01 << i, rdv);
    chk("flag_n", 8'h00, {7'h0, fault_flag_n});
    chk("halt", {7'h0, ~halts(c)}, {7'h0, switching_on});
    fault_in[i] = 1'b0;
    cyc(8);
    chk("hold", {7'h0, ~halts(c)}, {7'h0, switching_on});
    cyc(32);
    chk("restart", {7'h0, c != LBF_RESP_LATCH}, {7'h0, switching_on});
    // the latch must let go on either enable pin
    if (i == 1) chip_enable = 1'b0;
    else sw_enable = 1'b0;
    cyc(4);
    chip_enable = 1'b1;
    sw_enable = 1'b1;
    cyc(6);
    chk("release", 8'h01, {7'h0, switching_on});
    u_lbf_mcu_model.clear_faults(ctrl);
    cyc(3);
    chk("flag_idle", 8'h01, {7'h0, fault_flag_n});
    $display("test event %0d code %0d done", i, c);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    #200us;
    bad_count++;
    test_done();
  end
  initial begin
    cyc(16);
    rstn = 1'b1;
    u_lbf_mcu_model.rd(LBF_ADDR_CTRL1, rdv);
    chk("reset_ctrl", LBF_RESET_VAL, rdv);
    u_lbf_mcu_model.rd(LBF_ADDR_RESP, rdv);
    chk("reset_resp", LBF_RESET_VAL, rdv);
    u_lbf_mcu_model.rd(LBF_ADDR_STATUS, rdv);
    chk("reset_status", LBF_RESET_VAL, rdv);
    chk("reset_flag_n", 8'h01, {7'h0, fault_flag_n});
    chk("reset_sw", 8'h01, {7'h0, switching_on});
    lfsr = next_rand(lfsr);
    u_lbf_mcu_model.wr(LBF_ADDR_RESP, lfsr[7:0]);
    u_lbf_mcu_model.wr(LBF_ADDR_STATUS, 8'hFF);
    u_lbf_mcu_model.wr(8'h55, 8'hFF);
    u_lbf_mcu_model.rd(LBF_ADDR_RESP, rdv);
    chk("resp_rw", lfsr[7:0], rdv);
    u_lbf_mcu_model.rd(LBF_ADDR_STATUS, rdv);
    chk("status_ro", 8'h00, rdv);
    u_lbf_mcu_model.rd(8'h55, rdv);
    chk("unmapped", 8'h00, rdv);
    $display("test registers done");
    ctrl = 8'h80;
    u_lbf_mcu_model.wr(LBF_ADDR_CTRL1, ctrl);
    for (int i = 0; i < 3; i++) begin
      for (int c = 0; c < 4; c++) begin
        u_lbf_mcu_model.wr(LBF_ADDR_RESP, 8'(c << (2 * i)));
        ev(i, lbf_resp_t'(c[1:0]));
      end
    end
    // fields disabled: latch everywhere in low_bus_fault_response_ctrl must be ignored
    ctrl = 8'h00;
    u_lbf_mcu_model.wr(LBF_ADDR_CTRL1, ctrl);
    u_lbf_mcu_model.wr(LBF_ADDR_RESP, 8'h2A);
    lfsr = next_rand(lfsr);
    ev(lfsr % 3, LBF_RESP_FLAG);
    strap_resp = LBF_RESP_HICCUP;
    u_lbf_mcu_model.wr(LBF_ADDR_RESP, 8'h00);
    ev(lfsr % 3, LBF_RESP_HICCUP);
    strap_resp = LBF_RESP_FLAG;
    // refault while the restart count runs
    ctrl = 8'h80;
    u_lbf_mcu_model.wr(LBF_ADDR_CTRL1, ctrl);
    u_lbf_mcu_model.wr(LBF_ADDR_RESP, 8'h01);
    fault_in[0] = 1'b1;
    cyc(6);
    fault_in[0] = 1'b0;
    cyc(12);
    fault_in[0] = 1'b1;
    cyc(4);
    fault_in[0] = 1'b0;
    cyc(15);
    chk("refault_hold", 8'h00, {7'h0, switching_on});
    cyc(25);
    chk("refault_end", 8'h01, {7'h0, switching_on});
    u_lbf_mcu_model.clear_faults(ctrl);
    $display("test refault done");
    // clear with a fault that persists
    fault_in[1] = 1'b1;
    cyc(6);
    u_lbf_mcu_model.wr(LBF_ADDR_CTRL1, 8'hC0);
    u_lbf_mcu_model.rd(LBF_ADDR_STATUS, rdv);
    chk("clearing", 8'h00, rdv);
    u_lbf_mcu_model.wr(LBF_ADDR_CTRL1, 8'h80);
    u_lbf_mcu_model.rd(LBF_ADDR_STATUS, rdv);
    chk("persist", 8'h02, rdv);
    fault_in[1] = 1'b0;
    cyc(4);
    u_lbf_mcu_model.clear_faults(ctrl);
    u_lbf_mcu_model.rd(LBF_ADDR_STATUS, rdv);
    chk("cleared", 8'h00, rdv);
    $display("test clear done");
    test_done();
  end
endmodule
